// file: src/haptic_mode_control.sv
`timescale 1ns/10ps

// Overview of operation
// [R01] soft reset acts like a power cycle
// [R02] soft reset aborts playback, restores register defaults
// [R03] soft reset bit clears itself when done
// [R04] bit 6 is standby, defaults to one
// [R05] mode 0 fires on software fire bit
// [R06] mode 1 rising trigger edge sets fire
// [R07] mode 1 second rise while firing cancels
// [R08] mode 2 fire bit follows trigger level
// [R09] mode 3 drives from pin pwm/analog
// [R10] input type bit picks pwm or analog
// [R11] mode 4 converts audio on pin
// [R12] host sets coupling and input type first
// [R13] mode 5 drives realtime amplitude register
// [R14] mode 6 runs diagnostic, stores result
// [R15] host sets fire, device clears at end
// [R16] host programs calibration inputs before fire
// [R17] calibration end clears the fire bit
// [R18] outcome flag: last routine, clear on read
// [R19] mode bits 5..3 read zero, ignore writes

`include "haptic_consts.svh"

module haptic_mode_control
  import haptic_pkg::*;
#(
  parameter int SRST_CYCLES = `SRST_CYCLES,
  parameter int ROUTINE_CYCLES = `ROUTINE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic input_trigger_pin,
  input wire logic input_type_analog,
  input wire logic playback_done,
  input wire logic actuator_fault,
  output logic device_standby,
  output logic engine_fire,
  output logic engine_abort,
  output logic drive_enable,
  output drive_src_t drive_source,
  output logic [7:0] drive_amplitude
);

  localparam int SCW = $clog2(SRST_CYCLES + 1);

  // ****************************************************
  // mode decoding
  // ****************************************************
  function automatic logic is_trig_mode(op_mode_t m);
    return (m == MODE_INT_TRIG) || (m == MODE_EDGE_TRIG) ||
      (m == MODE_LEVEL_TRIG);
  endfunction : is_trig_mode

  function automatic logic is_routine_mode(op_mode_t m);
    return (m == MODE_DIAG) || (m == MODE_AUTOCAL);
  endfunction : is_routine_mode

  // ****************************************************
  // trigger pin synchroniser
  // ****************************************************
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  logic trig_lvl_q, trig_lvl_d;
  logic trig_agree, trig_rise, trig_fall;

  // change counts once stages two and three agree
  always_comb begin
    trig_agree = (trig_s2_q == trig_s3_q);
    trig_rise = trig_agree && trig_s3_q && !trig_lvl_q;
    trig_fall = trig_agree && !trig_s3_q && trig_lvl_q;
    trig_lvl_d = trig_agree ? trig_s3_q : trig_lvl_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
      trig_lvl_q <= 1'b0;
    end else begin
      trig_s1_q <= input_trigger_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      trig_lvl_q <= trig_lvl_d;
    end
  end

  // ****************************************************
  // register state
  // ****************************************************
  logic [SCW-1:0] srst_cnt_q, srst_cnt_d;
  logic standby_q, standby_d;
  op_mode_t opmode_q, opmode_d;
  logic [7:0] rtp_q, rtp_d;
  logic go_q, go_d;
  logic outcome_q, outcome_d;
  logic [7:0] rdata_q, rdata_d;
  logic abort_q, abort_d;
  logic srst_busy, srst_start;
  logic wr_mode, wr_rtp, wr_go, rd_status;
  logic go_set, go_clr;

  routine_if rt ();

  routine_sequencer #(
    .RUN_CYCLES(ROUTINE_CYCLES)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .rt(rt.seq),
    .actuator_fault(actuator_fault)
  );

  // routine request toward the sequencer
  always_comb begin
    rt.req = go_q && is_routine_mode(opmode_q) && !srst_busy;
    rt.calibrate = (opmode_q == MODE_AUTOCAL);
    rt.abort = srst_busy;
  end

  // access decode and fire bit events
  always_comb begin
    srst_busy = (srst_cnt_q != '0);
    wr_mode = reg_wr && (reg_addr == `ADDR_MODE) && !srst_busy;
    wr_rtp = reg_wr && (reg_addr == `ADDR_RTP) && !srst_busy;
    wr_go = reg_wr && (reg_addr == `ADDR_GO) && !srst_busy;
    rd_status = reg_rd && (reg_addr == `ADDR_STATUS);
    srst_start = wr_mode && reg_wdata[`MODE_SRST_BIT];
    // [R05] software fire
    go_set = wr_go && reg_wdata[`GO_BIT];
    go_clr = wr_go && !reg_wdata[`GO_BIT];
    // [R06] edge trigger sets
    if (opmode_q == MODE_EDGE_TRIG) begin
      go_set = go_set || (trig_rise && !go_q);
      // [R07] second edge cancels
      go_clr = go_clr || (trig_rise && go_q);
    end
    // [R08] level trigger follows pin
    if (opmode_q == MODE_LEVEL_TRIG) begin
      go_set = go_set || trig_rise;
      go_clr = go_clr || trig_fall;
    end
    // [R15] [R17] routine end clears
    go_clr = go_clr || rt.done;
    go_clr = go_clr || (playback_done && is_trig_mode(opmode_q));
  end

  // next values of the register file
  always_comb begin
    srst_cnt_d = srst_cnt_q;
    standby_d = standby_q;
    opmode_d = opmode_q;
    rtp_d = rtp_q;
    go_d = go_q;
    outcome_d = outcome_q;
    abort_d = 1'b0;
    // [R14] [R18] store routine result
    if (rt.done) begin
      outcome_d = rt.fail;
    end else if (rd_status) begin
      outcome_d = 1'b0;
    end
    // set wins over clear
    if (go_set) begin
      go_d = 1'b1;
    end else if (go_clr) begin
      go_d = 1'b0;
      abort_d = go_q && !rt.done && !playback_done;
    end
    if (wr_rtp) begin
      rtp_d = reg_wdata;
    end
    // [R19] reserved bits dropped
    if (wr_mode) begin
      standby_d = reg_wdata[`MODE_STBY_BIT];
      opmode_d = op_mode_t'(reg_wdata[2:0]);
    end
    // [R01] soft power cycle
    if (srst_start || srst_busy) begin
      // [R02] abort and restore defaults
      standby_d = `STBY_RST;
      opmode_d = op_mode_t'(`OPMODE_RST);
      rtp_d = `RTP_RST;
      go_d = 1'b0;
      outcome_d = 1'b0;
      abort_d = srst_start;
    end
    // [R03] self clearing countdown
    if (srst_start) begin
      srst_cnt_d = SCW'(SRST_CYCLES);
    end else if (srst_busy) begin
      srst_cnt_d = srst_cnt_q - 1'b1;
    end
  end

  // read data, captured on the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_STATUS: rdata_d = {`DEVICE_ID, 1'b0, outcome_q, 3'h0};
        // [R19] reserved read zero
        `ADDR_MODE: rdata_d = {srst_busy, standby_q, 3'h0, opmode_q};
        `ADDR_RTP: rdata_d = rtp_q;
        `ADDR_GO: rdata_d = {7'h00, go_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      srst_cnt_q <= '0;
      // [R04] standby by default
      standby_q <= `STBY_RST;
      opmode_q <= op_mode_t'(`OPMODE_RST);
      rtp_q <= `RTP_RST;
      go_q <= 1'b0;
      outcome_q <= 1'b0;
      rdata_q <= 8'h00;
      abort_q <= 1'b0;
    end else begin
      srst_cnt_q <= srst_cnt_d;
      standby_q <= standby_d;
      opmode_q <= opmode_d;
      rtp_q <= rtp_d;
      go_q <= go_d;
      outcome_q <= outcome_d;
      rdata_q <= rdata_d;
      abort_q <= abort_d;
    end
  end

  // ****************************************************
  // drive path
  // ****************************************************
  logic fire_q, fire_d;
  logic den_q, den_d;
  drive_src_t src_q, src_d;
  logic [7:0] amp_q, amp_d;
  logic active;

  always_comb begin
    active = !standby_q && !srst_busy;
    fire_d = go_q && is_trig_mode(opmode_q) && active;
    den_d = 1'b0;
    src_d = SRC_NONE;
    amp_d = 8'h00;
    if (fire_d) begin
      src_d = SRC_LIBRARY;
    end
    case (opmode_q)
      // [R09] pin drive, [R10] type select
      MODE_PIN_DRIVE: begin
        den_d = active;
        src_d = input_type_analog ? SRC_PIN_ANALOG : SRC_PIN_PWM;
      end
      // [R11] audio to vibe
      MODE_AUDIO: begin
        den_d = active;
        src_d = SRC_AUDIO;
      end
      // [R13] realtime amplitude drive
      MODE_REALTIME: begin
        den_d = active;
        src_d = SRC_REALTIME;
        amp_d = active ? rtp_q : 8'h00;
      end
      default: den_d = fire_d;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fire_q <= 1'b0;
      den_q <= 1'b0;
      src_q <= SRC_NONE;
      amp_q <= 8'h00;
    end else begin
      fire_q <= fire_d;
      den_q <= den_d;
      src_q <= src_d;
      amp_q <= amp_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign device_standby = standby_q;
  assign engine_fire = fire_q;
  assign engine_abort = abort_q;
  assign drive_enable = den_q;
  assign drive_source = src_q;
  assign drive_amplitude = amp_q;

  // ****************************************************
  // checks
  // ****************************************************
  // last cycle of the countdown, counted from the cycle after the start
  localparam int SRST_LAST = SRST_CYCLES - 1;
  localparam int RUN_MAX = ROUTINE_CYCLES + 3;

  property p_srst_clears;
    @(posedge clk) disable iff (rst)
    srst_start |=> srst_busy ##[SRST_LAST:SRST_LAST] srst_busy
      ##1 !srst_busy;
  endproperty
  a_srst_clears: assert property (p_srst_clears) // [R03]
    else $error("soft reset bit did not self clear on time");

  property p_srst_defaults;
    @(posedge clk) disable iff (rst)
    srst_start |=> (rtp_q == `RTP_RST) && !go_q && !outcome_q &&
      (opmode_q == MODE_INT_TRIG);
  endproperty
  a_srst_defaults: assert property (p_srst_defaults) // [R02]
    else $error("registers not at defaults after soft reset");

  property p_srst_standby;
    @(posedge clk) disable iff (rst)
    $fell(srst_busy) |-> standby_q && !fire_q && !den_q;
  endproperty
  a_srst_standby: assert property (p_srst_standby) // [R04]
    else $error("device not in standby after soft reset");

  property p_edge_set;
    @(posedge clk) disable iff (rst)
    (opmode_q == MODE_EDGE_TRIG) && trig_rise && !go_q && !srst_busy
      |=> go_q;
  endproperty
  a_edge_set: assert property (p_edge_set) // [R06]
    else $error("edge trigger did not set fire bit");

  property p_edge_cancel;
    @(posedge clk) disable iff (rst)
    (opmode_q == MODE_EDGE_TRIG) && trig_rise && go_q && !go_set
      |=> !go_q ##1 !fire_q;
  endproperty
  a_edge_cancel: assert property (p_edge_cancel) // [R07]
    else $error("second edge did not cancel");

  property p_level_fall;
    @(posedge clk) disable iff (rst)
    (opmode_q == MODE_LEVEL_TRIG) && trig_fall && !go_set |=> !go_q;
  endproperty
  a_level_fall: assert property (p_level_fall) // [R08]
    else $error("falling trigger did not clear fire bit");

  property p_rtp_drive;
    @(posedge clk) disable iff (rst)
    (opmode_q == MODE_REALTIME) && active
      |=> drive_enable && (drive_amplitude == $past(rtp_q));
  endproperty
  a_rtp_drive: assert property (p_rtp_drive) // [R13]
    else $error("realtime amplitude not driven");

  property p_routine_ends;
    @(posedge clk) disable iff (rst)
    $rose(go_q) && is_routine_mode(opmode_q) && !rt.busy
      ##1 $stable(opmode_q) |-> ##[1:RUN_MAX] !go_q;
  endproperty
  a_routine_ends: assert property (p_routine_ends) // [R17]
    else $error("routine did not clear fire bit in time");

  property p_outcome_load;
    @(posedge clk) disable iff (rst)
    rt.done && !srst_busy |=> (outcome_q == $past(rt.fail));
  endproperty
  a_outcome_load: assert property (p_outcome_load) // [R14]
    else $error("routine result not stored");

  property p_read_clear;
    @(posedge clk) disable iff (rst)
    rd_status && !rt.done |=> !outcome_q;
  endproperty
  a_read_clear: assert property (p_read_clear) // [R18]
    else $error("outcome flag not cleared by read");

  property p_rsv_zero;
    @(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `ADDR_MODE) |=> (reg_rdata[5:3] == 3'h0);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // [R19]
    else $error("reserved mode bits read nonzero");

  c_diag_fail: cover property (@(posedge clk) disable iff (rst)
    rt.done && rt.fail && !rt.calibrate);
  c_cal_done: cover property (@(posedge clk) disable iff (rst)
    rt.done && rt.calibrate);
  c_edge_cancel: cover property (@(posedge clk) disable iff (rst)
    (opmode_q == MODE_EDGE_TRIG) && trig_rise && go_q);
  c_soft_reset: cover property (@(posedge clk) disable iff (rst)
    $fell(srst_busy));

endmodule : haptic_mode_control

// file: src/haptic_consts.svh
`ifndef HAPTIC_CONSTS_SVH
`define HAPTIC_CONSTS_SVH

// ****************************************************
// register offsets
// ****************************************************
`define ADDR_STATUS 8'h00
`define ADDR_MODE 8'h01
`define ADDR_RTP 8'h02
`define ADDR_GO 8'h0c

// ****************************************************
// field positions
// ****************************************************
`define MODE_SRST_BIT 7
`define MODE_STBY_BIT 6
`define GO_BIT 0
`define STAT_OUTCOME_BIT 3

// ****************************************************
// reset values
// ****************************************************
`define STBY_RST 1'h1
`define OPMODE_RST 3'h0
`define RTP_RST 8'h00
// identifier value is arbitrary
`define DEVICE_ID 3'h2

// ****************************************************
// timing counts in clk cycles
// ****************************************************
`define SRST_CYCLES 4
`define ROUTINE_CYCLES 64

`endif

// file: src/haptic_pkg.sv
package haptic_pkg;

  // ****************************************************
  // operating modes
  // ****************************************************
  typedef enum logic [2:0] {
    MODE_INT_TRIG = 3'b000,
    MODE_EDGE_TRIG = 3'b001,
    MODE_LEVEL_TRIG = 3'b010,
    MODE_PIN_DRIVE = 3'b011,
    MODE_AUDIO = 3'b100,
    MODE_REALTIME = 3'b101,
    MODE_DIAG = 3'b110,
    MODE_AUTOCAL = 3'b111
  } op_mode_t;

  // drive source shown to the output stage
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_LIBRARY = 3'b001,
    SRC_PIN_PWM = 3'b010,
    SRC_PIN_ANALOG = 3'b011,
    SRC_AUDIO = 3'b100,
    SRC_REALTIME = 3'b101
  } drive_src_t;

  // routine sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_FINISH = 2'b10
  } seq_state_t;

endpackage : haptic_pkg

// file: src/routine_if.sv
`timescale 1ns/10ps

// request and answer between mode control and routine sequencer
interface routine_if;
  logic req;
  logic calibrate;
  logic abort;
  logic busy;
  logic done;
  logic fail;

  modport ctl (output req, output calibrate, output abort,
    input busy, input done, input fail);
  modport seq (input req, input calibrate, input abort,
    output busy, output done, output fail);
endinterface : routine_if

// file: src/routine_sequencer.sv
`timescale 1ns/10ps
`include "haptic_consts.svh"

module routine_sequencer
  import haptic_pkg::*;
#(
  parameter int RUN_CYCLES = `ROUTINE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  routine_if.seq rt,
  input wire logic actuator_fault
);

  localparam int CW = $clog2(RUN_CYCLES + 1);

  seq_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic fail_q, fail_d;

  // ****************************************************
  // sequencing of diagnostic and calibration runs
  // ****************************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    fail_d = fail_q;
    case (state_q)
      SEQ_IDLE: begin
        if (rt.req && !rt.abort) begin
          state_d = SEQ_RUN;
          cnt_d = CW'(RUN_CYCLES - 1);
          fail_d = 1'b0;
        end
      end
      SEQ_RUN: begin
        // any fault seen during the run fails it
        fail_d = fail_q | actuator_fault;
        if (cnt_q == '0) begin
          state_d = SEQ_FINISH;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      SEQ_FINISH: state_d = SEQ_IDLE;
      default: state_d = SEQ_IDLE;
    endcase
    if (rt.abort) begin
      state_d = SEQ_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SEQ_IDLE;
      cnt_q <= '0;
      fail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      fail_q <= fail_d;
    end
  end

  // answer toward mode control
  assign rt.busy = (state_q != SEQ_IDLE);
  assign rt.done = (state_q == SEQ_FINISH) && !rt.abort;
  assign rt.fail = fail_q;

  // ****************************************************
  // checks
  // ****************************************************
  property p_done_once;
    @(posedge clk) disable iff (rst)
    rt.done |=> !rt.done;
  endproperty
  a_done_once: assert property (p_done_once) // [R15]
    else $error("done held for more than one cycle");

endmodule : routine_sequencer

// file: tb/host_model.sv
`timescale 1ns/10ps

// ****************************************************
// host processor model on the register port
// ****************************************************
module host_model (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // drop strobes; released lines show the inverse of the last value
  task automatic release_bus();
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : release_bus

  // one write, taken at the next rising edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    release_bus();
  endtask : wr

  // one read, data registered at the taking edge and sampled a cycle and a half later
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = addr;
    release_bus();
    @(negedge clk);
    data = reg_rdata;
  endtask : rd

  // host starts routine
  // caller has already written every routine parameter
  task automatic fire();
    wr(8'h0c, 8'h01);
  endtask : fire
endmodule : host_model

// file: tb/haptic_mode_control_tb.sv
`timescale 1ns/10ps
`include "haptic_consts.svh"

module haptic_mode_control_tb
  import haptic_pkg::*;
  ;
  localparam int SRST_N = 4;
  localparam int ROUT_N = 8;
  localparam int TIMEOUT = 20000;

  typedef struct packed {
    logic [7:0] wdata;
    logic analog;
    logic [7:0] rdata;
    logic en;
    drive_src_t src;
    logic [7:0] amp;
  } row_t;

  // mode writes and the drive they should give (rtp holds 0x5a)
  localparam row_t ROWS [6] = '{
    '{8'h3b, 1'b0, 8'h03, 1'b1, SRC_PIN_PWM, 8'h00},
    '{8'h03, 1'b1, 8'h03, 1'b1, SRC_PIN_ANALOG, 8'h00},
    '{8'h04, 1'b1, 8'h04, 1'b1, SRC_AUDIO, 8'h00},
    '{8'h05, 1'b0, 8'h05, 1'b1, SRC_REALTIME, 8'h5a},
    '{8'h45, 1'b0, 8'h45, 1'b0, SRC_REALTIME, 8'h00},
    '{8'h00, 1'b0, 8'h00, 1'b0, SRC_NONE, 8'h00}
  };

  logic clk, rst, reg_wr, reg_rd, pin, analog, pb_done, fault;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, amp;
  logic standby, fire_o, abort_o, drive_en;
  drive_src_t src;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int abort_cnt = 0;

  haptic_mode_control #(.SRST_CYCLES(SRST_N), .ROUTINE_CYCLES(ROUT_N))
    haptic_mode_control_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .input_trigger_pin(pin),
    .input_type_analog(analog), .playback_done(pb_done),
    .actuator_fault(fault), .device_standby(standby),
    .engine_fire(fire_o), .engine_abort(abort_o), .drive_enable(drive_en),
    .drive_source(src), .drive_amplitude(amp));

  host_model host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // clock, 50 ns period
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // count abort pulses once the edge has settled
  always @(posedge clk) begin
    #1;
    if (abort_o === 1'b1) abort_cnt++;
  end

  // ****************************************************
  // checking and closing
  // ****************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    logic [7:0] d;
    int a0;
    int k;
    rst = 1'b1;
    pin = 1'b0;
    analog = 1'b0;
    pb_done = 1'b0;
    fault = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // defaults after reset
    host_model_inst.rd(`ADDR_MODE, d);
    check(d, 8'h40);
    check({7'h00, standby}, 8'h01);
    host_model_inst.rd(`ADDR_STATUS, d);
    check(d, {`DEVICE_ID, 5'h00});
    $display("test reset done");
    // table of drive modes
    host_model_inst.wr(`ADDR_RTP, 8'h5a);
    for (int i = 0; i < 6; i++) begin
      // input type set before audio mode
      analog = ROWS[i].analog;
      host_model_inst.wr(`ADDR_MODE, ROWS[i].wdata);
      repeat (3) @(negedge clk);
      check({7'h00, drive_en}, {7'h00, ROWS[i].en});
      check({5'h00, src}, {5'h00, ROWS[i].src});
      check(amp, ROWS[i].amp);
      check({7'h00, standby}, {7'h00, ROWS[i].wdata[6]});
      host_model_inst.rd(`ADDR_MODE, d);
      check(d, ROWS[i].rdata);
    end
    $display("test drive table done");
    // internal trigger by the fire bit, ended by the engine
    host_model_inst.fire();
    repeat (2) @(negedge clk);
    check({7'h00, fire_o}, 8'h01);
    check({5'h00, src}, {5'h00, SRC_LIBRARY});
    pb_done = 1'b1;
    @(negedge clk);
    pb_done = 1'b0;
    host_model_inst.rd(`ADDR_GO, d);
    check(d, 8'h00);
    $display("test internal trigger done");
    // edge trigger: fall ignored, second rise cancels
    host_model_inst.wr(`ADDR_MODE, 8'h01);
    pin = 1'b1;
    repeat (8) @(negedge clk);
    check({7'h00, fire_o}, 8'h01);
    a0 = abort_cnt;
    pin = 1'b0;
    repeat (8) @(negedge clk);
    check({7'h00, fire_o}, 8'h01);
    pin = 1'b1;
    repeat (8) @(negedge clk);
    check({7'h00, fire_o}, 8'h00);
    check(8'(abort_cnt - a0), 8'h01);
    pin = 1'b0;
    repeat (8) @(negedge clk);
    $display("test edge trigger done");
    // level trigger follows the pin
    host_model_inst.wr(`ADDR_MODE, 8'h02);
    pin = 1'b1;
    repeat (8) @(negedge clk);
    check({7'h00, fire_o}, 8'h01);
    a0 = abort_cnt;
    pin = 1'b0;
    repeat (8) @(negedge clk);
    check({7'h00, fire_o}, 8'h00);
    check(8'(abort_cnt - a0), 8'h01);
    $display("test level trigger done");
    // diagnostic with fault, then calibration clean
    for (int i = 0; i < 2; i++) begin
      fault = (i == 0);
      host_model_inst.wr(`ADDR_MODE, (i == 0) ? 8'h06 : 8'h07);
      host_model_inst.fire();
      host_model_inst.rd(`ADDR_GO, d);
      check(d, 8'h01);
      k = 0;
      while (d[0] !== 1'b0 && k < 40) begin
        host_model_inst.rd(`ADDR_GO, d);
        k++;
      end
      check(d, 8'h00);
      host_model_inst.rd(`ADDR_STATUS, d);
      check(d, {`DEVICE_ID, 1'b0, fault, 3'h0});
      host_model_inst.rd(`ADDR_STATUS, d);
      check(d, {`DEVICE_ID, 5'h00});
    end
    fault = 1'b0;
    $display("test routines done");
    // soft reset in the middle of realtime drive
    host_model_inst.wr(`ADDR_MODE, 8'h05);
    repeat (2) @(negedge clk);
    check({7'h00, drive_en}, 8'h01);
    a0 = abort_cnt;
    host_model_inst.wr(`ADDR_MODE, 8'h80);
    host_model_inst.rd(`ADDR_MODE, d);
    check(d, 8'hc0);
    repeat (SRST_N + 4) @(negedge clk);
    host_model_inst.rd(`ADDR_MODE, d);
    check(d, 8'h40);
    host_model_inst.rd(`ADDR_RTP, d);
    check(d, 8'h00);
    check({7'h00, drive_en}, 8'h00);
    check(8'(abort_cnt - a0), 8'h01);
    $display("test soft reset done");
    report_and_stop();
  end
endmodule : haptic_mode_control_tb
